// ### dv/lcbu_fetch_model.sv
// Fetch-side model: hands back the two delay-slot words of a delayed branch.
// Assumes go_i is high at the edge where a delayed branch is issued.
`timescale 1ns/1ps
`default_nettype none
module lcbu_fetch_model (
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   input  wire logic       go_i,
   input  wire logic [3:0] gap_i,
   output logic            slot_word_o
);
   int k;
   initial begin
      slot_word_o = 1'b0;
      forever begin
         @(posedge clk_i);
         if (go_i && nrst_i) begin
            // Stalls of gap_i cycles mimic slow program memory
            for (k = 0; k < 2; k++) begin
               repeat (gap_i + 1) @(posedge clk_i);
               slot_word_o <= 1'b1;
               @(posedge clk_i);
               slot_word_o <= 1'b0;
            end
         end
      end
   end
endmodule : lcbu_fetch_model
`default_nettype wire

// ### dv/tb_loop_and_conditional_branch_unit.sv
// Testbench for the branch unit: branch sequences with expected program counter.
// Assumes the fetch model returns slot words after each delayed branch.
`timescale 1ns/1ps
`default_nettype none
module tb_loop_and_conditional_branch_unit;
   logic clk;
   logic nrst = 1'b0, issue = 1'b0, rpt = 1'b0, go = 1'b0, aux_wr = 1'b0, ce = 1'b1;
   logic cy = 1'b0, srf = 1'b0, tcf = 1'b0, pin = 1'b1, fv = 1'b0, slot;
   logic [1:0] op = 2'h0, amod = 2'h0, pfs = 2'h0;
   logic [2:0] ptr = 3'h5;
   logic [3:0] mask = 4'h0, val = 4'h0, gap = 4'h0;
   logic [15:0] tgt = 16'h0000, aux_data = 16'h0000, cnt_exp = 16'h0000;
   logic [31:0] sum = 32'h0000_0000;
   logic [15:0] prog_cnt, aux;
   logic busy, flush, taken, nrep;
   int err_total = 0, comparisons = 0, i;

   lcbu_top u_lcbu_top (.clk_i(clk), .nrst_i(nrst), .ce_i(ce), .issue_i(issue), .op_i(op),
      .target_i(tgt), .aux_pointer_i(ptr), .aux_mod_i(amod), .in_repeat_i(rpt),
      .main_sum_reg_i(sum), .cond_select_mask_i(mask), .cond_value_i(val),
      .pin_flag_select_i(pfs), .flag_value_i(fv), .carry_i(cy), .signed_range_flag_i(srf),
      .test_result_flag_i(tcf), .branch_input_pin_i(pin), .slot_word_i(slot),
      .aux_wr_i(aux_wr), .aux_wr_sel_i(ptr), .aux_wr_data_i(aux_data),
      .program_counter_o(prog_cnt), .busy_o(busy), .flush_o(flush), .taken_o(taken),
      .not_repeatable_o(nrep), .aux_register_o(aux));
   lcbu_fetch_model u_lcbu_fetch_model (.clk_i(clk), .nrst_i(nrst), .go_i(go),
      .gap_i(gap), .slot_word_o(slot));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic tick;
      @(posedge clk);
      #1;
   endtask : tick

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic give_verdict;
      if (err_total == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict

   // One branch; delayed conditional also flips carry to prove early sampling
   task automatic branch(input logic [1:0] o, input logic [15:0] t, input logic tk);
      int nb, nf, n;
      logic [15:0] base;
      logic [15:0] cost;
      base = cnt_exp;
      nb = 0;
      nf = 0;
      tick();
      op = o;
      tgt = t;
      issue = 1'b1;
      go = o[0];
      tick();
      issue = 1'b0;
      go = 1'b0;
      if (o == 2'h3) cy = ~cy;
      // Sample from the cycle right after issue: flush and busy start there
      for (n = 0; n < 24; n++) begin
         if (n == 0 && o[0]) chk("delayed step", base + 16'h0002, prog_cnt);
         if (flush === 1'b1) nf++;
         if (busy !== 1'b1) break;
         nb++;
         tick();
      end
      cnt_exp = tk ? t : base + (o[0] ? 16'h0004 : 16'h0002);
      // Cost counts the issue cycle too, busy covers the rest
      cost = tk ? 16'(lcbu_pkg::CYC_TAKEN) : 16'(lcbu_pkg::CYC_FALL);
      chk("program counter", cnt_exp, prog_cnt);
      chk("taken", {15'h0000, tk}, {15'h0000, taken});
      chk("flush count", o[0] ? 16'h0000 : {15'h0000, tk}, 16'(nf));
      if (!o[0]) chk("busy cycles", cost - 16'h0001, 16'(nb));
   endtask : branch

   // Flags packed as carry, overflow, test flag, pin, wanted flag value
   task automatic cond_case(input logic [1:0] o, input logic [31:0] a, input logic [4:0] f,
                            input logic [3:0] m, input logic [3:0] v, input logic [1:0] s,
                            input logic tk);
      sum = a;
      {cy, srf, tcf, pin, fv} = f;
      mask = m;
      val = v;
      pfs = s;
      repeat (4) tick();
      branch(o, 16'h1230, tk);
   endtask : cond_case

   task automatic loop_case(input logic [1:0] o, input logic [1:0] m, input logic tk,
                            input logic [15:0] a);
      amod = m;
      branch(o, 16'h0080, tk);
      chk("aux after loop branch", a, aux);
   endtask : loop_case

   initial begin
      #100000;
      err_total++;
      give_verdict();
   end

   initial begin
      repeat (4) @(posedge clk);
      #1;
      nrst = 1'b1;
      repeat (3) tick();
      // Preload N-1 so the loop body runs three times
      aux_wr = 1'b1;
      aux_data = 16'h0002;
      tick();
      aux_wr = 1'b0;
      tick();
      chk("aux preload", 16'h0002, aux);
      for (i = 0; i < 3; i++) loop_case(2'h0, 2'h0, i < 2, 16'h0001 - 16'(i));
      loop_case(2'h0, 2'h2, 1'b1, 16'h0000);
      loop_case(2'h0, 2'h2, 1'b0, 16'h0001);
      loop_case(2'h0, 2'h1, 1'b1, 16'h0001);
      gap = 4'h2;
      loop_case(2'h1, 2'h0, 1'b1, 16'h0000);
      loop_case(2'h1, 2'h0, 1'b0, 16'hffff);
      cond_case(2'h2, 32'h0000_0000, 5'h02, 4'h8, 4'h8, 2'h0, 1'b1);
      cond_case(2'h2, 32'h0000_0005, 5'h02, 4'h8, 4'h8, 2'h0, 1'b0);
      cond_case(2'h2, 32'h0000_0005, 5'h02, 4'h8, 4'h0, 2'h0, 1'b1);
      cond_case(2'h2, 32'hffff_fff0, 5'h02, 4'hc, 4'h4, 2'h0, 1'b1);
      cond_case(2'h2, 32'h0000_0000, 5'h02, 4'hc, 4'h4, 2'h0, 1'b0);
      cond_case(2'h2, 32'h0000_0000, 5'h02, 4'hc, 4'hc, 2'h0, 1'b1);
      cond_case(2'h2, 32'h0000_0005, 5'h02, 4'hc, 4'h0, 2'h0, 1'b1);
      cond_case(2'h2, 32'h0000_0000, 5'h02, 4'hc, 4'h0, 2'h0, 1'b0);
      cond_case(2'h2, 32'h0000_0000, 5'h02, 4'hc, 4'h8, 2'h0, 1'b1);
      cond_case(2'h2, 32'hffff_fff0, 5'h02, 4'hc, 4'h8, 2'h0, 1'b0);
      cond_case(2'h2, 32'h0000_0005, 5'h12, 4'h1, 4'h1, 2'h0, 1'b1);
      cond_case(2'h2, 32'h0000_0005, 5'h12, 4'h1, 4'h0, 2'h0, 1'b0);
      cond_case(2'h2, 32'h0000_0005, 5'h0a, 4'h2, 4'h2, 2'h0, 1'b1);
      cond_case(2'h2, 32'h0000_0005, 5'h02, 4'h2, 4'h0, 2'h0, 1'b1);
      cond_case(2'h2, 32'h0000_0005, 5'h07, 4'h0, 4'h0, 2'h1, 1'b1);
      cond_case(2'h2, 32'h0000_0005, 5'h06, 4'h0, 4'h0, 2'h1, 1'b0);
      cond_case(2'h2, 32'h0000_0005, 5'h00, 4'h0, 4'h0, 2'h2, 1'b1);
      cond_case(2'h2, 32'h0000_0005, 5'h02, 4'h0, 4'h0, 2'h2, 1'b0);
      cond_case(2'h2, 32'h0000_0005, 5'h02, 4'h0, 4'h0, 2'h0, 1'b1);
      cond_case(2'h2, 32'h0000_0000, 5'h02, 4'hd, 4'hd, 2'h0, 1'b0);
      cond_case(2'h2, 32'h0000_0000, 5'h12, 4'hd, 4'hd, 2'h0, 1'b1);
      gap = 4'h0;
      cond_case(2'h3, 32'h0000_0005, 5'h12, 4'h1, 4'h1, 2'h0, 1'b1);
      cond_case(2'h3, 32'h0000_0005, 5'h12, 4'h1, 4'h0, 2'h0, 1'b0);
      for (i = 0; i < 4; i++) begin
         tick();
         op = 2'(i);
         rpt = 1'b1;
         issue = 1'b1;
         tick();
         // Refusal pulse stands for one cycle only
         chk("not repeatable", 16'h0001, {15'h0000, nrep});
         chk("busy on refusal", 16'h0000, {15'h0000, busy});
         issue = 1'b0;
         rpt = 1'b0;
         repeat (3) tick();
         chk("count on refusal", cnt_exp, prog_cnt);
      end
      // Enable low freezes the unit even with an unconditional branch presented
      ce = 1'b0;
      op = 2'h2;
      mask = 4'h0;
      pfs = 2'h0;
      issue = 1'b1;
      repeat (3) tick();
      chk("count while frozen", cnt_exp, prog_cnt);
      chk("busy while frozen", 16'h0000, {15'h0000, busy});
      issue = 1'b0;
      ce = 1'b1;
      repeat (2) tick();
      chk("count after freeze", cnt_exp, prog_cnt);
      give_verdict();
   end
endmodule : tb_loop_and_conditional_branch_unit
`default_nettype wire

// ### src/lcbu_cond_eval.sv
// Condition evaluator for the conditional branch.
// Assumes flag inputs are already in the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module lcbu_cond_eval (
   input  wire logic [31:0] main_sum_reg_i,
   input  wire logic [3:0]  cond_select_mask_i,
   input  wire logic [3:0]  cond_value_i,
   input  wire logic [1:0]  pin_flag_select_i,
   input  wire logic        flag_value_i,
   input  wire logic        carry_i,
   input  wire logic        signed_range_flag_i,
   input  wire logic        test_result_flag_i,
   input  wire logic        branch_input_pin_i,
   output logic             met_o
);
   logic zero;
   logic neg;
   logic ok_z;
   logic ok_l;
   logic ok_v;
   logic ok_c;
   logic ok_p;
   always_comb begin
      zero = (main_sum_reg_i == 32'h0000_0000);
      neg  = main_sum_reg_i[31];
      // Z and L combine: Z+L=LEQ, Z+!L=GEQ, !Z+L=LT, !Z+!L=GT, as a pair
      ok_z = 1'b1;
      ok_l = 1'b1;
      if (cond_select_mask_i[lcbu_pkg::M_Z] && cond_select_mask_i[lcbu_pkg::M_L]) begin
         ok_z = cond_value_i[lcbu_pkg::M_Z] ? (cond_value_i[lcbu_pkg::M_L] ? (zero | neg)
                                                                         : (zero | !neg))
                                           : (cond_value_i[lcbu_pkg::M_L] ? neg
                                                                         : (!zero & !neg));
      end else if (cond_select_mask_i[lcbu_pkg::M_Z]) begin
         ok_z = (zero == cond_value_i[lcbu_pkg::M_Z]);
      end else if (cond_select_mask_i[lcbu_pkg::M_L]) begin
         ok_l = (neg == cond_value_i[lcbu_pkg::M_L]);
      end
      ok_v = !cond_select_mask_i[lcbu_pkg::M_V]
             || (signed_range_flag_i == cond_value_i[lcbu_pkg::M_V]);
      ok_c = !cond_select_mask_i[lcbu_pkg::M_C]
             || (carry_i == cond_value_i[lcbu_pkg::M_C]);
      // 0: none, 1: test flag, 2: pin low; pin and flag are exclusive by encoding
      unique case (pin_flag_select_i)
         2'h1:    ok_p = (test_result_flag_i == flag_value_i);
         2'h2:    ok_p = !branch_input_pin_i;
         default: ok_p = 1'b1;
      endcase
      met_o = ok_z & ok_l & ok_v & ok_c & ok_p;
   end
endmodule : lcbu_cond_eval
`default_nettype wire

// ### src/lcbu_pkg.sv
// Package for the loop and conditional branch unit: constants and encodings.
// Assumes a 16-bit program address space and eight 16-bit auxiliary registers.
package lcbu_pkg;
   localparam int unsigned ADDR_W    = 16;
   localparam int unsigned AUX_N     = 8;
   localparam int unsigned PTR_W     = 3;
   localparam int unsigned ACC_W     = 32;
   localparam logic [15:0] PC_RESET  = 16'h0000;
   localparam logic [15:0] PC_STEP2  = 16'h0002;
   localparam logic [15:0] AUX_DEC   = 16'h0001;
   localparam logic [15:0] AUX_ZERO  = 16'h0000;
   // Cycle costs with zero-wait program memory
   localparam logic [2:0]  CYC_TAKEN = 3'h4;
   localparam logic [2:0]  CYC_FALL  = 3'h2;
   localparam logic [2:0]  CYC_DELAY = 3'h2;
   localparam logic [1:0]  SLOT_WORDS = 2'h2;
   // Opcode selector
   typedef enum logic [1:0] {
      LCBU_OP_LOOP   = 2'h0,
      LCBU_OP_LOOPD  = 2'h1,
      LCBU_OP_COND   = 2'h2,
      LCBU_OP_CONDD  = 2'h3
   } lcbu_op_e;
   // Auxiliary modify modes
   typedef enum logic [1:0] {
      LCBU_MOD_DEC  = 2'h0,
      LCBU_MOD_NONE = 2'h1,
      LCBU_MOD_INC  = 2'h2
   } lcbu_mod_e;
   // Condition mask bit positions (zero, less, overflow, carry)
   localparam int unsigned M_Z = 3;
   localparam int unsigned M_L = 2;
   localparam int unsigned M_V = 1;
   localparam int unsigned M_C = 0;
endpackage : lcbu_pkg

// ### src/lcbu_top.sv
// Loop and conditional branch unit: decision, program counter and aux update.
// Assumes the fetch pipeline presents a decoded two-word branch with its
// second word, and counts delay-slot words back through slot_word_i.
`timescale 1ns/1ps
`default_nettype none
module lcbu_top #(
   parameter int unsigned AUX_N = lcbu_pkg::AUX_N
) (
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        ce_i,
   input  wire logic        issue_i,
   input  wire logic [1:0]  op_i,
   input  wire logic [15:0] target_i,
   input  wire logic [2:0]  aux_pointer_i,
   input  wire logic [1:0]  aux_mod_i,
   input  wire logic        in_repeat_i,
   input  wire logic [31:0] main_sum_reg_i,
   input  wire logic [3:0]  cond_select_mask_i,
   input  wire logic [3:0]  cond_value_i,
   input  wire logic [1:0]  pin_flag_select_i,
   input  wire logic        flag_value_i,
   input  wire logic        carry_i,
   input  wire logic        signed_range_flag_i,
   input  wire logic        test_result_flag_i,
   input  wire logic        branch_input_pin_i,
   input  wire logic        slot_word_i,
   input  wire logic        aux_wr_i,
   input  wire logic [2:0]  aux_wr_sel_i,
   input  wire logic [15:0] aux_wr_data_i,
   output logic [15:0]      program_counter_o,
   output logic             busy_o,
   output logic             flush_o,
   output logic             taken_o,
   output logic             not_repeatable_o,
   output logic [15:0]      aux_register_o
);
   typedef enum logic [3:0] {
      LCBU_IDLE  = 4'b0001,
      LCBU_FLUSH = 4'b0010,
      LCBU_SLOT  = 4'b0100,
      LCBU_DONE  = 4'b1000
   } lcbu_state_e;

   typedef struct packed {
      lcbu_state_e             st;
      logic [2:0]              cyc;
      logic [1:0]              slots;
      logic                    take;
      logic [15:0]             tgt;
      logic [15:0]             pc;
      logic [AUX_N-1:0][15:0]  aux;
      logic                    busy;
      logic                    flush;
      logic                    taken;
      logic                    norep;
      logic [15:0]             aux_out;
      logic [2:0]              pin_sync;
      logic                    pin;
   } lcbu_state_s;

   lcbu_state_s r;
   lcbu_state_s next_r;
   logic        rst_m;
   logic        rst_n;
   logic        met;

   function automatic logic [15:0] lcbu_modify(input logic [15:0] v, input logic [1:0] m);
      unique case (m)
         lcbu_pkg::LCBU_MOD_NONE: lcbu_modify = v;
         lcbu_pkg::LCBU_MOD_INC:  lcbu_modify = 16'(v + lcbu_pkg::AUX_DEC);
         default:                 lcbu_modify = 16'(v - lcbu_pkg::AUX_DEC);
      endcase
   endfunction : lcbu_modify

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_m <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_m <= 1'b1;
         rst_n <= rst_m;
      end
   end

   lcbu_cond_eval u_cond (
      .main_sum_reg_i      (main_sum_reg_i),
      .cond_select_mask_i  (cond_select_mask_i),
      .cond_value_i        (cond_value_i),
      .pin_flag_select_i   (pin_flag_select_i),
      .flag_value_i        (flag_value_i),
      .carry_i             (carry_i),
      .signed_range_flag_i (signed_range_flag_i),
      .test_result_flag_i  (test_result_flag_i),
      .branch_input_pin_i  (r.pin),
      .met_o               (met)
   );

   always_comb begin
      logic        is_loop;
      logic        is_dly;
      logic        go;
      logic [15:0] cur;
      is_loop = 1'b0;
      is_dly  = 1'b0;
      go      = 1'b0;
      cur     = r.aux[aux_pointer_i];
      next_r  = r;
      // Pin from outside: three stages, change accepted when last two agree
      next_r.pin_sync = {r.pin_sync[1:0], branch_input_pin_i};
      if (r.pin_sync[2] == r.pin_sync[1]) begin
         next_r.pin = r.pin_sync[2];
      end
      next_r.flush = 1'b0;
      next_r.norep = 1'b0;
      if (aux_wr_i) begin
         next_r.aux[aux_wr_sel_i] = aux_wr_data_i;
      end
      unique case (r.st)
         LCBU_IDLE: begin
            if (issue_i && in_repeat_i) begin
               next_r.norep = 1'b1;
            end else if (issue_i) begin
               is_loop = (op_i == lcbu_pkg::LCBU_OP_LOOP) || (op_i == lcbu_pkg::LCBU_OP_LOOPD);
               is_dly  = (op_i == lcbu_pkg::LCBU_OP_LOOPD) || (op_i == lcbu_pkg::LCBU_OP_CONDD);
               // Decision fixed at issue so slot words cannot alter it
               go = is_loop ? (cur != lcbu_pkg::AUX_ZERO) : met;
               if (is_loop) begin
                  next_r.aux[aux_pointer_i] = lcbu_modify(cur, aux_mod_i);
               end
               next_r.take  = go;
               next_r.tgt   = target_i;
               next_r.busy  = 1'b1;
               next_r.taken = 1'b0;
               next_r.slots = 2'h0;
               if (is_dly) begin
                  next_r.st  = LCBU_SLOT;
                  next_r.cyc = lcbu_pkg::CYC_DELAY;
                  next_r.pc  = 16'(r.pc + lcbu_pkg::PC_STEP2);
               end else if (go) begin
                  next_r.st    = LCBU_FLUSH;
                  next_r.cyc   = lcbu_pkg::CYC_TAKEN;
                  next_r.flush = 1'b1;
               end else begin
                  next_r.st  = LCBU_DONE;
                  next_r.cyc = lcbu_pkg::CYC_FALL;
               end
            end
         end
         LCBU_FLUSH: begin
            next_r.cyc = 3'(r.cyc - 3'h1);
            // Redirect one cycle early so the done cycle is the last of the taken cost
            if (r.cyc == 3'(lcbu_pkg::CYC_TAKEN - 3'h1)) begin
               next_r.pc    = r.tgt;
               next_r.taken = 1'b1;
               next_r.st    = LCBU_DONE;
            end
         end
         LCBU_SLOT: begin
            if (r.cyc > 3'h1) begin
               next_r.cyc = 3'(r.cyc - 3'h1);
            end
            if (slot_word_i) begin
               next_r.slots = 2'(r.slots + 2'h1);
               next_r.pc    = 16'(r.pc + 16'h0001);
            end
            if (r.slots == lcbu_pkg::SLOT_WORDS) begin
               // Both slot words done: now redirect if taken
               if (r.take) begin
                  next_r.pc    = r.tgt;
                  next_r.taken = 1'b1;
               end
               next_r.busy = 1'b0;
               next_r.st   = LCBU_IDLE;
            end
         end
         LCBU_DONE: begin
            if (!r.take) begin
               next_r.pc = 16'(r.pc + lcbu_pkg::PC_STEP2);
            end
            next_r.busy = 1'b0;
            next_r.st   = LCBU_IDLE;
         end
         default: next_r.st = LCBU_IDLE;
      endcase
      next_r.aux_out = next_r.aux[aux_pointer_i];
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         r     <= '0;
         r.st  <= LCBU_IDLE;
         r.pc  <= lcbu_pkg::PC_RESET;
         // Pin stages start at the idle high level: no false pin low after reset
         r.pin_sync <= '1;
         r.pin      <= 1'b1;
      end else if (ce_i) begin
         r <= next_r;
      end
   end

   assign program_counter_o = r.pc;
   assign busy_o            = r.busy;
   assign flush_o           = r.flush;
   assign taken_o           = r.taken;
   assign not_repeatable_o  = r.norep;
   assign aux_register_o    = r.aux_out;

   a_loop_taken_pc: assert property (@(posedge clk_i) disable iff (!rst_n)
      (ce_i && r.st == LCBU_IDLE && issue_i && !in_repeat_i
       && op_i == lcbu_pkg::LCBU_OP_LOOP && r.aux[aux_pointer_i] != lcbu_pkg::AUX_ZERO)
      |=> (r.flush && r.tgt == $past(target_i)) ##2 (r.taken && r.pc == r.tgt))
      else $error("loop branch did not reach target");
   a_delay_step: assert property (@(posedge clk_i) disable iff (!rst_n)
      (ce_i && r.st == LCBU_IDLE && issue_i && !in_repeat_i
       && (op_i == lcbu_pkg::LCBU_OP_LOOPD || op_i == lcbu_pkg::LCBU_OP_CONDD))
      |=> (r.st == LCBU_SLOT && !r.flush
           && r.pc == 16'($past(r.pc) + lcbu_pkg::PC_STEP2)))
      else $error("delayed branch did not step past its two words");
   a_fall_through_cost: assert property (@(posedge clk_i) disable iff (!rst_n)
      (ce_i && r.st == LCBU_IDLE && issue_i && !in_repeat_i
       && op_i == lcbu_pkg::LCBU_OP_COND && !met)
      |=> (r.st == LCBU_DONE && !r.flush))
      else $error("untaken branch did not go to done");
   a_taken_flush: assert property (@(posedge clk_i) disable iff (!rst_n)
      (ce_i && r.st == LCBU_IDLE && issue_i && !in_repeat_i
       && op_i == lcbu_pkg::LCBU_OP_COND && met)
      |=> (r.flush && r.st == LCBU_FLUSH))
      else $error("taken branch did not flush");
   a_aux_decrement: assert property (@(posedge clk_i) disable iff (!rst_n)
      (ce_i && r.st == LCBU_IDLE && issue_i && !in_repeat_i && !aux_wr_i
       && op_i == lcbu_pkg::LCBU_OP_LOOP && aux_mod_i == 2'h0)
      |=> (r.aux[$past(aux_pointer_i)] == 16'($past(r.aux[aux_pointer_i]) - 16'h0001)))
      else $error("aux register not decremented");
   a_repeat_refused: assert property (@(posedge clk_i) disable iff (!rst_n)
      (ce_i && r.st == LCBU_IDLE && issue_i && in_repeat_i)
      |=> (r.norep && r.st == LCBU_IDLE && !r.busy))
      else $error("branch accepted under repeat");
   a_delay_no_flush: assert property (@(posedge clk_i) disable iff (!rst_n)
      (r.st == LCBU_SLOT) |-> !r.flush)
      else $error("delayed branch flushed slot words");
   a_delay_stable: assert property (@(posedge clk_i) disable iff (!rst_n)
      (r.st == LCBU_SLOT && $past(r.st) == LCBU_SLOT) |-> $stable(r.take))
      else $error("delayed decision changed");
   a_target_load: assert property (@(posedge clk_i) disable iff (!rst_n)
      $rose(r.taken) |-> (r.pc == r.tgt))
      else $error("program counter not at target");
endmodule : lcbu_top
`default_nettype wire
